// [hw/bus_matrix_map.svh]
// address map and reset values for the bus matrix with its error monitor
// assumes a 32-bit flat address space shared by both masters
`ifndef BUS_MATRIX_MAP_SVH
`define BUS_MATRIX_MAP_SVH

// slave areas: base and mask of a power-of-two window each
`define CODE_FLASH_BASE 32'h0000_0000
`define CODE_FLASH_MASK 32'hfff0_0000
`define SRAM_BASE 32'h2000_0000
`define SRAM_MASK 32'hffff_0000
`define SYSCTL_BASE 32'h4001_0000
`define SYSCTL_MASK 32'hffff_0000
`define PERIPH_BASE 32'h4004_0000
`define PERIPH_MASK 32'hfffc_0000
`define ENTROPY_BASE 32'h400d_0000
`define ENTROPY_MASK 32'hffff_0000
`define FLASHPE_BASE 32'h4010_0000
`define FLASHPE_MASK 32'hfff0_0000

// fault records after reset
`define FAULT_ADDR_RESET 32'h0000_0000
`define FAULT_STAT_RESET 1'b0

// slave port count
`define SLAVE_COUNT 6

`endif

// [hw/bus_matrix_pkg.sv]
// types shared by the bus matrix files
// assumes AHB-Lite signalling on every master and slave port
package bus_matrix_pkg;
	// request phase of one AHB-Lite port
	typedef struct packed {
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
	} ahb_req_s;

	// response of one AHB-Lite port
	typedef struct packed {
		logic [31:0] hrdata;
		logic hready;
		logic hresp;
	} ahb_rsp_s;

	// slave port index
	typedef enum logic [2:0] {
		SLV_CODE = 3'h0,
		SLV_SRAM = 3'h1,
		SLV_SYSCTL = 3'h2,
		SLV_PERIPH = 3'h3,
		SLV_ENTROPY = 3'h4,
		SLV_FLASHPE = 3'h5,
		SLV_NONE = 3'h7
	} slave_e;

	// processor error response sequence
	typedef enum logic [1:0] {
		ERR_IDLE = 2'b00,
		ERR_FIRST = 2'b01,
		ERR_SECOND = 2'b11
	} err_state_e;
endpackage

// [hw/fault_record.sv]
// holds the fault address and fault flag of one bus master
// assumes capture is a one-cycle pulse; only reset empties the record
`timescale 1ns/1ps
`include "bus_matrix_map.svh"

module fault_record
	import bus_matrix_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// capture strobe and address
	input wire logic capture,
	input wire logic [31:0] faultAddr,
	// stored record
	output logic [31:0] masterFaultAddress,
	output logic masterFaultStatus
);
	// only the first fault is kept, so the log points at the root cause
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			masterFaultAddress <= `FAULT_ADDR_RESET;
			masterFaultStatus <= `FAULT_STAT_RESET;
		end else if (capture && !masterFaultStatus) begin
			masterFaultAddress <= faultAddr;
			masterFaultStatus <= 1'b1;
		end
	end
endmodule // fault_record

// [hw/bus_matrix.sv]
// What this block does
// - two masters, processor and transfer controller, reach memory and peripherals
// - separate slave ports: code flash, primary_sram, four peripheral buses
// - memory space is little-endian; bytes pass unswapped
// - each slave area is checked independently on every access
// - an access to no legal area is a bus error
// - processor errors return the two-cycle AHB-Lite ERROR response
// - an erroneous access is not forwarded to any slave
// - each master keeps its own fault address and status record
// - fault records clear only on reset, never by writes
// - transfer controller never sees an error response
//
// bus matrix for two AHB-Lite masters and six slave ports, with error logging
// assumes one clock; the processor has fixed priority over the transfer
// controller; slaves are AHB-Lite and answer with hreadyout
`timescale 1ns/1ps
`include "bus_matrix_map.svh"

module bus_matrix
	import bus_matrix_pkg::*;
#(
	parameter int SLAVES = `SLAVE_COUNT
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// processor system bus
	input wire ahb_req_s cpuReq,
	output ahb_rsp_s cpuRsp,
	// transfer controller bus
	input wire ahb_req_s transferControllerReq,
	output ahb_rsp_s transferControllerRsp,
	// slave ports: code, primary_sram, sysctl, periph, entropy_source, flash p/e
	output ahb_req_s [SLAVES-1:0] slaveReq,
	output logic [SLAVES-1:0] slaveSel,
	input wire ahb_rsp_s [SLAVES-1:0] slaveRsp,
	// per-master fault records
	output logic [31:0] cpuFaultAddress,
	output logic cpuFaultStatus,
	output logic [31:0] transferControllerFaultAddress,
	output logic transferControllerFaultStatus
);
	// area decode, shared by both masters
	function automatic slave_e decodeArea(input logic [31:0] a);
		slave_e s;
		s = SLV_NONE;
		if ((a & `CODE_FLASH_MASK) == `CODE_FLASH_BASE) s = SLV_CODE;
		if ((a & `SRAM_MASK) == `SRAM_BASE) s = SLV_SRAM;
		if ((a & `SYSCTL_MASK) == `SYSCTL_BASE) s = SLV_SYSCTL;
		if ((a & `PERIPH_MASK) == `PERIPH_BASE) s = SLV_PERIPH;
		if ((a & `ENTROPY_MASK) == `ENTROPY_BASE) s = SLV_ENTROPY;
		if ((a & `FLASHPE_MASK) == `FLASHPE_BASE) s = SLV_FLASHPE;
		return s;
	endfunction

	function automatic logic isActive(input logic [1:0] t);
		return t[1]; // nonseq or seq
	endfunction

	// current address phase
	logic cpuValid, dtcValid;
	slave_e cpuArea, dtcArea;
	logic cpuBad, dtcBad;
	logic grantCpu, grantDtc;
	logic dataBusy;

	// data phase state
	logic dataCpu_q, dataDtc_q;
	slave_e dataArea_q;
	err_state_e errState_q;
	// transfer controller request held while the processor or a stalled data phase blocks it
	logic dtcPending_q;
	ahb_req_s dtcHeld_q;
	ahb_req_s dtcCur;

	assign cpuValid = isActive(cpuReq.htrans);
	assign dtcCur = dtcPending_q ? dtcHeld_q : transferControllerReq;
	assign dtcValid = dtcPending_q || isActive(transferControllerReq.htrans);
	assign cpuArea = decodeArea(cpuReq.haddr);
	assign dtcArea = decodeArea(dtcCur.haddr);
	assign cpuBad = cpuValid && (cpuArea == SLV_NONE);
	assign dtcBad = dtcValid && (dtcArea == SLV_NONE);

	// a slave data phase still running blocks new address phases
	logic slaveReady;
	assign slaveReady = (dataArea_q == SLV_NONE) ? 1'b1
		: slaveRsp[dataArea_q].hready;
	assign dataBusy = ((dataCpu_q || dataDtc_q) && !slaveReady)
		|| (errState_q == ERR_FIRST);

	// processor has priority; hazard: the controller waits, never drops
	assign grantCpu = cpuValid && !dataBusy;
	assign grantDtc = dtcValid && !dataBusy && !cpuValid;

	// latch a controller request that loses arbitration
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dtcPending_q <= 1'b0;
			dtcHeld_q <= '0;
		end else if (grantDtc) begin
			dtcPending_q <= 1'b0;
		end else if (!dtcPending_q && isActive(transferControllerReq.htrans)) begin
			dtcPending_q <= 1'b1;
			dtcHeld_q <= transferControllerReq;
		end
	end

	// data phase ownership and target
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dataCpu_q <= 1'b0;
			dataDtc_q <= 1'b0;
			dataArea_q <= SLV_NONE;
		end else if (!dataBusy) begin
			dataCpu_q <= grantCpu;
			dataDtc_q <= grantDtc;
			dataArea_q <= grantCpu ? cpuArea : (grantDtc ? dtcArea : SLV_NONE);
		end
	end

	// two-cycle error answer for the processor only
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			errState_q <= ERR_IDLE;
		end else begin
			case (errState_q)
				ERR_IDLE: if (grantCpu && cpuBad) errState_q <= ERR_FIRST;
				ERR_FIRST: errState_q <= ERR_SECOND;
				ERR_SECOND: begin
					if (grantCpu && cpuBad) errState_q <= ERR_FIRST;
					else errState_q <= ERR_IDLE;
				end
				default: errState_q <= ERR_IDLE;
			endcase
		end
	end

	// route address phase; a bad access selects no slave
	always_comb begin
		for (int i = 0; i < SLAVES; i++) begin
			slaveReq[i] = grantCpu ? cpuReq : dtcCur;
			slaveReq[i].hwdata = dataCpu_q ? cpuReq.hwdata
				: transferControllerReq.hwdata;
			slaveSel[i] = (grantCpu && cpuArea == slave_e'(i))
				|| (grantDtc && dtcArea == slave_e'(i));
		end
	end

	// processor answer
	always_comb begin
		cpuRsp.hrdata = (dataCpu_q && dataArea_q != SLV_NONE)
			? slaveRsp[dataArea_q].hrdata : 32'h0000_0000;
		cpuRsp.hresp = (errState_q != ERR_IDLE);
		cpuRsp.hready = (errState_q == ERR_FIRST) ? 1'b0
			: (errState_q == ERR_SECOND) ? 1'b1
			: (dataCpu_q ? slaveReady : 1'b1);
		// a refused processor request must wait, or it would be lost
		if (!dataCpu_q && !grantCpu && cpuValid && errState_q == ERR_IDLE)
			cpuRsp.hready = 1'b0;
	end

	// controller answer: waits on slaves, never an error
	always_comb begin
		transferControllerRsp.hrdata = (dataDtc_q && dataArea_q != SLV_NONE)
			? slaveRsp[dataArea_q].hrdata : 32'h0000_0000;
		transferControllerRsp.hresp = 1'b0;
		transferControllerRsp.hready = dataDtc_q ? slaveReady
			: !dtcPending_q;
	end

	// fault records, one per master
	fault_record cpuRecord (
		.clock(clock),
		.rst(rst),
		.capture(grantCpu && cpuBad),
		.faultAddr(cpuReq.haddr),
		.masterFaultAddress(cpuFaultAddress),
		.masterFaultStatus(cpuFaultStatus)
	);
	fault_record dtcRecord (
		.clock(clock),
		.rst(rst),
		.capture(grantDtc && dtcBad),
		.faultAddr(dtcCur.haddr),
		.masterFaultAddress(transferControllerFaultAddress),
		.masterFaultStatus(transferControllerFaultStatus)
	);

	// error response is exactly low-then-high ready with hresp held
	errorTwoCycle_a: assert property (@(posedge clock) disable iff (rst)
		(grantCpu && cpuBad) |=> (cpuRsp.hresp && !cpuRsp.hready)
		##1 (cpuRsp.hresp && cpuRsp.hready))
		else $error("processor error response not two cycles");

	dtcNoError_a: assert property (@(posedge clock) disable iff (rst)
		!transferControllerRsp.hresp)
		else $error("transfer controller got an error response");

	badNoSelect_a: assert property (@(posedge clock) disable iff (rst)
		(grantCpu && cpuBad) |-> (slaveSel == '0))
		else $error("bad access reached a slave");

	faultLogged_a: assert property (@(posedge clock) disable iff (rst)
		(grantCpu && cpuBad && !cpuFaultStatus) |=>
		(cpuFaultStatus && cpuFaultAddress == $past(cpuReq.haddr)))
		else $error("processor fault not logged");

	faultHeld_a: assert property (@(posedge clock) disable iff (rst)
		cpuFaultStatus |=> (cpuFaultStatus && $stable(cpuFaultAddress)))
		else $error("fault record changed without reset");

	dtcLogged_a: assert property (@(posedge clock) disable iff (rst)
		(grantDtc && dtcBad) |=> transferControllerFaultStatus)
		else $error("controller fault not logged");

	goodRouted_a: assert property (@(posedge clock) disable iff (rst)
		(grantCpu && !cpuBad) |-> $onehot(slaveSel))
		else $error("legal access not routed to one slave");

	cpuPriority_a: assert property (@(posedge clock) disable iff (rst)
		(cpuValid && !dataBusy) |-> (grantCpu && !grantDtc))
		else $error("processor lost arbitration");

	// a processor request that is not granted is stalled, not dropped
	cpuRefusedWaits_a: assert property (@(posedge clock) disable iff (rst)
		(cpuValid && !grantCpu && !dataCpu_q && errState_q == ERR_IDLE)
		|-> !cpuRsp.hready)
		else $error("refused processor request not stalled");

	dtcHeld_a: assert property (@(posedge clock) disable iff (rst)
		transferControllerFaultStatus |=> (transferControllerFaultStatus
		&& $stable(transferControllerFaultAddress)))
		else $error("controller fault record changed without reset");
endmodule // bus_matrix

// [dv/slave_model.sv]
// answers every slave port of the bus matrix with a patterned read value
// assumes one clock; the matrix copies one request to all ports
`timescale 1ns/1ps

module slave_model
	import bus_matrix_pkg::*;
#(
	parameter int N = 6
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// matrix side
	input wire ahb_req_s [N-1:0] slaveReq,
	input wire logic [N-1:0] slaveSel,
	output ahb_rsp_s [N-1:0] slaveRsp,
	// one wait state per access when set
	input wire logic slow
);
	logic [N-1:0] dataQ;
	logic [N-1:0] waitQ;
	logic [31:0] addrQ;

	// take the address phase; a slow slave stalls its data phase once
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dataQ <= '0;
			waitQ <= '0;
			addrQ <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (slaveSel[i] && slaveReq[i].htrans[1]) begin
					dataQ[i] <= 1'b1;
					waitQ[i] <= slow;
					addrQ <= slaveReq[i].haddr;
				end else if (waitQ[i]) begin
					waitQ[i] <= 1'b0;
				end else begin
					dataQ[i] <= 1'b0;
				end
			end
		end
	end

	// outside a data phase the data bus shows the inverse, never stale data
	always_comb begin
		for (int i = 0; i < N; i++) begin
			slaveRsp[i].hready = !waitQ[i];
			slaveRsp[i].hresp = 1'b0;
			slaveRsp[i].hrdata = dataQ[i] ? addrQ ^ 32'h5a5a_5a5a
				: ~(addrQ ^ 32'h5a5a_5a5a);
		end
	end
endmodule // slave_model

// [dv/bus_matrix_bench.sv]
// self-checking bench for the bus matrix and its fault records
// assumes slave_model on the slave side; bench plays both masters
`timescale 1ns/1ps
`include "bus_matrix_map.svh"

module bus_matrix_bench
	import bus_matrix_pkg::*;
;
	typedef struct packed {
		logic chk;
		logic resp;
		logic [31:0] data;
	} exp_s;
	localparam logic [31:0] BASE [6] = '{`CODE_FLASH_BASE, `SRAM_BASE,
		`SYSCTL_BASE, `PERIPH_BASE, `ENTROPY_BASE, `FLASHPE_BASE};
	localparam logic [31:0] MASK [6] = '{`CODE_FLASH_MASK, `SRAM_MASK,
		`SYSCTL_MASK, `PERIPH_MASK, `ENTROPY_MASK, `FLASHPE_MASK};
	logic clock, rst, slow, useTc, dph;
	ahb_req_s cpuReq, transferControllerReq, req;
	ahb_rsp_s cpuRsp, transferControllerRsp, rsp;
	ahb_req_s [5:0] slaveReq;
	ahb_rsp_s [5:0] slaveRsp;
	logic [5:0] slaveSel;
	logic [31:0] cpuFaultAddress, transferControllerFaultAddress, a;
	logic cpuFaultStatus, transferControllerFaultStatus;
	exp_s expQ[$];
	exp_s note;
	int miscompares, compares, cycles;

	bus_matrix #(.SLAVES(6)) uut (.clock(clock), .rst(rst),
		.cpuReq(cpuReq), .cpuRsp(cpuRsp),
		.transferControllerReq(transferControllerReq),
		.transferControllerRsp(transferControllerRsp),
		.slaveReq(slaveReq), .slaveSel(slaveSel), .slaveRsp(slaveRsp),
		.cpuFaultAddress(cpuFaultAddress), .cpuFaultStatus(cpuFaultStatus),
		.transferControllerFaultAddress(transferControllerFaultAddress),
		.transferControllerFaultStatus(transferControllerFaultStatus));
	slave_model #(.N(6)) far (.clock(clock), .rst(rst), .slaveReq(slaveReq),
		.slaveSel(slaveSel), .slaveRsp(slaveRsp), .slow(slow));

	// the master under test this transfer
	assign req = useTc ? transferControllerReq : cpuReq;
	assign rsp = useTc ? transferControllerRsp : cpuRsp;

	always #10 clock = ~clock;

	task automatic check(input string what, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic report_and_stop();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// one read; sl is the expected slave port, negative when illegal
	task automatic xfer(input bit tc, input logic [31:0] ad, input int sl);
		ahb_req_s r;
		exp_s e;
		r = '{haddr: ad, htrans: 2'b10, hwrite: 1'b0, hsize: 3'h2,
			hwdata: $urandom};
		e = '{chk: sl >= 0, resp: sl < 0 && !tc, data: ad ^ 32'h5a5a_5a5a};
		useTc <= tc;
		if (tc)
			transferControllerReq <= r;
		else
			cpuReq <= r;
		do @(posedge clock); while (!rsp.hready);
		check("slaveSel", sl < 0 ? 32'h0 : 32'h1 << sl, 32'(slaveSel));
		if (sl >= 0)
			check("slaveReq addr", ad, slaveReq[sl].haddr);
		expQ.push_back(e);
		r.htrans = 2'b00;
		if (tc)
			transferControllerReq <= r;
		else
			cpuReq <= r;
		do @(posedge clock); while (!rsp.hready);
	endtask

	// compare each finished data phase with the oldest note
	always @(posedge clock) begin
		if (dph && rsp.hready) begin
			note = expQ.pop_front();
			check("hresp", 32'(note.resp), 32'(rsp.hresp));
			if (note.chk)
				check("hrdata", note.data, rsp.hrdata);
		end
		// a stalled data phase keeps its flag until ready comes
		if (rst || rsp.hready)
			dph <= !rst && req.htrans[1] && rsp.hready;
	end

	// hang guard, well above the fewer than a hundred cycles the tests need
	always @(posedge clock) begin
		cycles++;
		if (cycles > 3000) begin
			miscompares++;
			report_and_stop();
		end
	end

	initial begin
		clock = 0;
		rst = 1;
		slow = 0;
		useTc = 0;
		dph = 0;
		cpuReq = '0;
		transferControllerReq = '0;
		void'($urandom(98612));
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		check("cpu status", 32'h0, 32'(cpuFaultStatus));
		// every area, code/sysctl/entropy from the processor, sram/periph/flash p/e from the controller; last round at top of each window
		for (int k = 0; k < 24; k++) begin
			slow <= k[2];
			a = k >= 18 ? ~MASK[k % 6] : $urandom & ~MASK[k % 6];
			xfer(k[0], BASE[k % 6] | (a & 32'hffff_fffc), k % 6);
		end
		xfer(1'b0, 32'h3000_0000, -1);
		check("cpu status", 32'h1, 32'(cpuFaultStatus));
		check("cpu addr", 32'h3000_0000, cpuFaultAddress);
		xfer(1'b0, 32'h2001_0000, -1);
		check("cpu addr", 32'h3000_0000, cpuFaultAddress);
		xfer(1'b1, 32'h4003_fffc, -1);
		check("tc status", 32'h1, 32'(transferControllerFaultStatus));
		check("tc addr", 32'h4003_fffc, transferControllerFaultAddress);
		xfer(1'b0, `SRAM_BASE | 32'h10, 1);
		// second reset in mid-run empties both records
		rst <= 1'b1;
		@(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		check("cpu addr", 32'h0, cpuFaultAddress);
		check("tc status", 32'h0, 32'(transferControllerFaultStatus));
		report_and_stop();
	end
endmodule // bus_matrix_bench
